// *** cap_backend_model.sv ***
// behavioural backend memory answering forwarded host accesses
module cap_backend_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request from the port
  input wire cap_pkg::cap_mem_req_t mem_req,
  // stall controls from the bench
  input wire logic deny,
  input wire logic [3:0] stall,
  // answers to the port
  output logic backend_grant_n,
  output logic backend_not_ready_n,
  output logic [15:0] backend_read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] junk;
  logic [3:0] cnt;
  assign backend_grant_n = deny;
  // not ready for the first stall cycles of each backend cycle
  assign backend_not_ready_n = !(mem_req.rd || mem_req.wr) || cnt >= stall;
  // high address bits fold into the answer so a dropped address bit shows
  // an idle bus carries a changing pattern, never the last word
  assign backend_read_data = (mem_req.rd && backend_not_ready_n) ?
    mem[mem_req.addr[3:0]] ^ {mem_req.addr[15:4], 4'h0} : junk;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      junk <= 16'hA5A5;
    end else begin
      junk <= ~junk;
      cnt <= (mem_req.rd || mem_req.wr) ? cnt + ((cnt != 4'hF) ? 4'h1 : 4'h0) : 4'h0;
      if (mem_req.wr && backend_not_ready_n)
        mem[mem_req.addr[3:0]] <= mem_req.wdata;
    end
  end
endmodule

// *** cap_host_port.sv ***
// host processor access port with register and backend memory paths
`include "cap_regs.svh"
module cap_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host side
  input wire logic host_port_select_n,
  input wire logic [1:0] host_byte_write_n,
  input wire logic host_read_strobe_n,
  input wire logic host_target_is_memory,
  input wire logic [15:0] host_address,
  input wire logic [15:0] host_write_data,
  output logic [15:0] host_read_data,
  output logic host_data_drive_enable,
  output logic host_wait_n,
  // internal register file
  output logic [2:0] reg_index,
  output logic [15:0] reg_write_data,
  output logic [1:0] reg_byte_write,
  output logic reg_write,
  output logic reg_read,
  input wire logic [15:0] reg_read_data,
  // backend memory
  output cap_pkg::cap_mem_req_t mem_req,
  input wire logic [15:0] backend_read_data,
  input wire logic backend_grant_n,
  input wire logic backend_not_ready_n
);
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic [1:0] wr_n;
    logic to_mem;
    logic [15:0] addr;
    logic [15:0] wdata;
    cap_pkg::cap_state_t state;
    logic [2:0] cnt;
    logic is_rd;
    logic [15:0] rdata;
    logic den;
    logic wait_n;
    logic [2:0] ridx;
    logic [15:0] rwd;
    logic [1:0] rbw;
    logic rwr;
    logic rrd;
    cap_pkg::cap_mem_req_t mreq;
  } cap_port_state_t;

  cap_port_state_t st;
  cap_port_state_t next_st;
  logic reg_rd_d;
  logic reg_wr_d;
  logic mem_rd_d;
  logic mem_wr_d;

  cap_reg_select u_sel (
    .sel_n(st.sel_n),
    .rd_n(st.rd_n),
    .wr_n(st.wr_n),
    .to_mem(st.to_mem),
    .reg_rd(reg_rd_d),
    .reg_wr(reg_wr_d),
    .mem_rd(mem_rd_d),
    .mem_wr(mem_wr_d)
  );

  always_comb begin
    next_st = st;
    // inputs are on the same clock, so one sampling stage only
    next_st.sel_n = host_port_select_n;
    next_st.rd_n = host_read_strobe_n;
    next_st.wr_n = host_byte_write_n;
    next_st.to_mem = host_target_is_memory;
    next_st.addr = host_address;
    next_st.wdata = host_write_data;
    next_st.rwr = 1'b0;
    next_st.rrd = 1'b0;
    next_st.mreq.rd = 1'b0;
    next_st.mreq.wr = 1'b0;
    case (st.state)
      cap_pkg::CAP_IDLE: begin
        next_st.wait_n = 1'b1;
        if (reg_rd_d) begin
          next_st.ridx = st.addr[`CAP_RAW-1:0];
          // register file answers for the index set one edge earlier, so the
          // enable waits a cycle rather than show the previous register
          next_st.rrd = !st.den && !st.rrd;
          next_st.rdata = reg_read_data;
          next_st.den = st.rrd || st.den;
        end else if (reg_wr_d) begin
          next_st.ridx = st.addr[`CAP_RAW-1:0];
          next_st.rwd = st.wdata;
          // upper strobe bit selects the low byte lane
          next_st.rbw[0] = !st.wr_n[`CAP_LO_BYTE_STROBE];
          next_st.rbw[1] = !st.wr_n[`CAP_HI_BYTE_STROBE];
          next_st.rwr = !st.rwr && (st.rbw == 2'h0 || st.den);
          next_st.den = 1'b0;
        end else if (mem_rd_d || mem_wr_d) begin
          next_st.den = 1'b0;
          next_st.wait_n = 1'b0;
          next_st.is_rd = mem_rd_d;
          next_st.cnt = mem_rd_d ? `CAP_RD_MIN_WAIT : `CAP_WR_MIN_WAIT;
          next_st.mreq.addr = st.addr;
          next_st.mreq.wdata = st.wdata;
          next_st.mreq.byte_wr = ~st.wr_n;
          next_st.state = cap_pkg::CAP_GRANT;
        end else begin
          next_st.den = 1'b0;
          next_st.rbw = 2'h0;
        end
      end
      cap_pkg::CAP_GRANT: begin
        next_st.wait_n = 1'b0;
        if (st.cnt != `CAP_CNT_ZERO) begin
          next_st.cnt = st.cnt - `CAP_CNT_ONE;
        end
        if (!backend_grant_n) begin
          next_st.mreq.rd = st.is_rd;
          next_st.mreq.wr = !st.is_rd;
          next_st.state = cap_pkg::CAP_XFER;
        end
      end
      cap_pkg::CAP_XFER: begin
        next_st.wait_n = 1'b0;
        if (st.cnt != `CAP_CNT_ZERO) begin
          next_st.cnt = st.cnt - `CAP_CNT_ONE;
        end
        if (!backend_not_ready_n) begin
          next_st.mreq.rd = st.is_rd;
          next_st.mreq.wr = !st.is_rd;
        end else begin
          if (st.is_rd) begin
            next_st.rdata = backend_read_data;
          end
          next_st.state = cap_pkg::CAP_DONE;
        end
      end
      cap_pkg::CAP_DONE: begin
        if (st.cnt > `CAP_CNT_ONE) begin
          next_st.cnt = st.cnt - `CAP_CNT_ONE;
          next_st.wait_n = 1'b0;
        end else begin
          next_st.cnt = `CAP_CNT_ZERO;
          next_st.wait_n = 1'b1;
          next_st.den = st.is_rd;
        end
        // hold until the host drops its strobe so one strobe makes one backend access
        if (st.wait_n && (st.sel_n || (st.rd_n && st.wr_n == 2'h3))) begin
          next_st.den = 1'b0;
          next_st.state = cap_pkg::CAP_IDLE;
        end
      end
      default: begin
        next_st.state = cap_pkg::CAP_IDLE;
        next_st.wait_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.sel_n <= 1'b1;
      st.rd_n <= 1'b1;
      st.wr_n <= 2'h3;
      st.wait_n <= 1'b1;
      st.state <= cap_pkg::CAP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign host_read_data = st.rdata;
  assign host_data_drive_enable = st.den;
  assign host_wait_n = st.wait_n;
  assign reg_index = st.ridx;
  assign reg_write_data = st.rwd;
  assign reg_byte_write = st.rbw;
  assign reg_write = st.rwr;
  assign reg_read = st.rrd;
  assign mem_req = st.mreq;

  // after one idle cycle with no request, wait never drops on a register read
  AST_NO_WAIT_REG: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == cap_pkg::CAP_IDLE && !reg_rd_d && !reg_wr_d && !mem_rd_d && !mem_wr_d ##1
     reg_rd_d) |=> host_wait_n)
    else $error("wait asserted on register access");
  AST_RD_MIN_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(host_wait_n) && st.is_rd |-> !host_wait_n [*4])
    else $error("read wait shorter than four cycles");
  AST_WR_MIN_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(host_wait_n) && !st.is_rd |-> !host_wait_n [*3])
    else $error("write wait shorter than three cycles");
  AST_GRANT_HOLDS: assert property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_GRANT && backend_grant_n |=> !host_wait_n)
    else $error("wait released without grant");
  AST_NOT_READY_HOLDS: assert property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_XFER && !backend_not_ready_n |=>
      !host_wait_n && mem_req.rd == st.is_rd && mem_req.wr == !st.is_rd)
    else $error("wait released while backend not ready");
  AST_DEN_READ_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    host_data_drive_enable |-> host_wait_n && (st.state == cap_pkg::CAP_IDLE || st.is_rd))
    else $error("data enable outside a read");
  AST_SELECT_GATES: assert property (@(posedge ref_clk) disable iff (rst)
    st.sel_n && st.state == cap_pkg::CAP_IDLE |=> !reg_write && host_wait_n)
    else $error("access taken without select");
  AST_REG_INDEX: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd_d && st.state == cap_pkg::CAP_IDLE |=> reg_index == $past(st.addr[2:0]))
    else $error("register index not from address");
  AST_BYTE_LANE: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr_d && st.state == cap_pkg::CAP_IDLE |=> reg_byte_write[0] == !$past(st.wr_n[1]))
    else $error("upper strobe did not select low byte");
  AST_MEM_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_IDLE && (mem_rd_d || mem_wr_d) |=>
      mem_req.addr == $past(st.addr) && mem_req.wdata == $past(st.wdata))
    else $error("memory request address or data not taken from host");
  COV_MEM_READ: cover property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_DONE && st.is_rd && host_wait_n);
  COV_MEM_WRITE: cover property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_DONE && !st.is_rd && host_wait_n);
  COV_REG_WRITE: cover property (@(posedge ref_clk) disable iff (rst) reg_write);
  COV_NOT_READY: cover property (@(posedge ref_clk) disable iff (rst)
    st.state == cap_pkg::CAP_XFER && !backend_not_ready_n);
endmodule

// *** cap_pkg.sv ***
// types for the host access port
package cap_pkg;
  typedef enum logic [1:0] {CAP_IDLE, CAP_GRANT, CAP_XFER, CAP_DONE} cap_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0] byte_wr;
    logic rd;
    logic wr;
  } cap_mem_req_t;
endpackage

// *** cap_reg_select.sv ***
// decode of a host access into register or memory request
`include "cap_regs.svh"
module cap_reg_select (
  // host request, already registered
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic [1:0] wr_n,
  input wire logic to_mem,
  // decoded request
  output logic reg_rd,
  output logic reg_wr,
  output logic mem_rd,
  output logic mem_wr
);
  logic active;
  logic any_wr;
  always_comb begin
    active = !sel_n;
    any_wr = active && (wr_n != 2'h3);
    reg_rd = active && !rd_n && !to_mem;
    reg_wr = any_wr && !to_mem;
    mem_rd = active && !rd_n && to_mem;
    mem_wr = any_wr && to_mem && rd_n;
  end
endmodule

// *** cap_regs.svh ***
// constants and rule summary for the host access port
// Summary of operation
// - Every host port input and output is sampled and driven on the master clock edge.
// - Strobes are ignored unless the active-low port select is low.
// - Two active-low byte write strobes; the upper strobe bit low writes data bits 7 to 0 (register writes only; memory byte_wr is ~wr_n unswapped).
// - Read strobe low together with port select is a read request.
// - Target select 0 reaches internal registers by address bits 2 to 0, 1 forwards to memory.
// - Wait is never asserted for internal register accesses.
// - Forwarded accesses hold wait at least four cycles on reads and three on writes.
// - Wait is extended while the backend withholds grant or reports not ready.
// - Data enable is high exactly while read data is presented on the output bus.
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH
`define CAP_DW 16
`define CAP_RAW 3
`define CAP_RD_MIN_WAIT 3'h4
`define CAP_WR_MIN_WAIT 3'h3
`define CAP_CNT_ONE 3'h1
`define CAP_CNT_ZERO 3'h0
`define CAP_DATA_ZERO 16'h0000
`define CAP_LO_BYTE_STROBE 1
`define CAP_HI_BYTE_STROBE 0
`endif

// *** testbench.sv ***
// self-checking bench for the host access port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, sel_n, rd_n, tgt, den, wait_n, reg_write, deny, grant_n, nrdy_n, den_q;
  logic [1:0] wr_n, reg_bw, w;
  logic [2:0] reg_index;
  logic [3:0] stall;
  logic [15:0] addr, wdata, rdata, reg_wd, reg_rd, be_rd, a, d;
  logic [20:0] expq [$];
  cap_pkg::cap_mem_req_t mem_req;
  integer n_mismatch, total_checks, seed, i;
  assign reg_rd = {4{1'b0, reg_index}};
  cap_host_port dut (.ref_clk(ref_clk), .rst(rst), .host_port_select_n(sel_n),
    .host_byte_write_n(wr_n), .host_read_strobe_n(rd_n), .host_target_is_memory(tgt),
    .host_address(addr), .host_write_data(wdata), .host_read_data(rdata),
    .host_data_drive_enable(den), .host_wait_n(wait_n), .reg_index(reg_index),
    .reg_write_data(reg_wd), .reg_byte_write(reg_bw), .reg_write(reg_write), .reg_read(),
    .reg_read_data(reg_rd), .mem_req(mem_req), .backend_read_data(be_rd),
    .backend_grant_n(grant_n), .backend_not_ready_n(nrdy_n));
  cap_backend_model backend (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .deny(deny),
    .stall(stall), .backend_grant_n(grant_n), .backend_not_ready_n(nrdy_n),
    .backend_read_data(be_rd));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // a result with no note queued is itself a mismatch
  task automatic take(input logic [20:0] v);
    if (expq.size() == 0) chk(21'h000000, 21'h000001);
    else chk(v, expq.pop_front());
  endtask
  always @(negedge ref_clk) begin
    if (!rst && den && !den_q) take({5'h00, rdata});
    if (!rst && reg_write) take({reg_index, reg_bw, reg_wd});
    den_q = den;
  end
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // inputs change on the falling edge only
  task automatic acc(input logic m, r, input logic [1:0] wn, input logic s, input integer gd);
    integer nw, k;
    @(negedge ref_clk);
    {sel_n, tgt, rd_n, wr_n, addr, wdata} = {s, m, ~r, wn, a, d};
    deny = (gd > 0);
    if (gd > 0) fork
      begin
        repeat (gd + 3) @(negedge ref_clk);
        deny = 1'b0;
      end
    join_none
    nw = 0;
    k = 0;
    // strobe stays down until wait is seen high again
    while (k < 80 && (k < 4 || !wait_n)) begin
      @(negedge ref_clk);
      nw += !wait_n;
      k++;
    end
    {sel_n, rd_n, wr_n} = 4'hF;
    @(negedge ref_clk);
    // a wait that never rises ran out of time
    chk(k < 80, 1);
    if (!m || s) chk(nw, 0);
    else chk(nw >= (r ? 4 : 3) && nw > gd + stall, 1);
  endtask
  initial begin
    seed = 45332;
    {n_mismatch, total_checks, den_q, deny, stall} = 0;
    {sel_n, rd_n, wr_n, tgt, addr, wdata, a, d} = {4'hF, 33'h0, 32'h0};
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 3; i++) begin
      a = 16'($random(seed));
      d = 16'($random(seed));
      w = 2'b11 ^ 2'(i + 1);
      expq.push_back({a[2:0], ~w[0], ~w[1], d});
      acc(1'b0, 1'b0, w, 1'b0, 0);
      expq.push_back({5'h00, {4{1'b0, a[2:0]}}});
      acc(1'b0, 1'b1, 2'b11, 1'b0, 0);
    end
    acc(1'b0, 1'b1, 2'b11, 1'b1, 0);
    acc(1'b0, 1'b0, 2'b00, 1'b1, 0);
    acc(1'b1, 1'b1, 2'b11, 1'b1, 0);
    for (i = 0; i < 6; i++) begin
      stall = 4'(i % 4);
      a = 16'($random(seed));
      d = 16'($random(seed));
      acc(1'b1, 1'b0, 2'b00, 1'b0, (i % 3) * 2);
      a[15:4] = 12'($random(seed));
      expq.push_back({5'h00, d ^ {a[15:4], 4'h0}});
      acc(1'b1, 1'b1, 2'b11, 1'b0, (i % 3) * 2);
    end
    chk(expq.size(), 0);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end
endmodule
